// ---- design/sbl_loader.sv ----
// serial bootstrap loader: sync, store, echo, idle timeout, jump
//
// Behaviour
// - bootstrap reset vectors into loader rom
// - bytes stored consecutively from 0x0080, size-limited
// - every program byte echoed on transmit pin
// - stop on ram full or four idle chars
// - afterwards jump to 0x0080
// - interrupt vectors routed to ram in bootstrap
// - transmit pin driven open drain only
`default_nettype none
module sbl_loader
  import sbl_pkg::*;
#(
  parameter int IDLE_LIMIT = sbl_pkg::IDLE_CYCLES  // shorten in simulation
) (
  input  wire logic                    clk_sys,
  input  wire logic                    reset,
  input  wire logic                    boot_mode,    // bootstrap strap
  input  wire logic                    big_ram,      // larger-ram variant
  input  wire logic                    rxd,          // async_serial_port receive
  output var  logic                    txd_o,        // transmit pin output value
  output var  logic                    txd_oe,       // high while pin pulled low
  output var  sbl_pkg::sbl_ram_wr_type ram_wr,       // ram write port
  output var  logic [15:0]             reset_vector, // vector taken at reset
  output var  logic                    vec_in_ram,   // interrupt vectors in ram
  output var  logic                    jump_valid,   // pulse: start loaded code
  output var  logic [15:0]             jump_addr,    // target of that jump
  output var  logic                    loading       // download in progress
);
  import sbl_pkg::*;

  // timing shorthand
  // one bit time in system clocks
  // the receiver starts half a bit late so every tick lands mid-bit
  // no oversampling and no majority vote: a clean host line is assumed
  // a noisy line may cost a byte, which the host sees as a missing echo
  localparam int BC = BIT_CYCLES;
  localparam int HALF = BIT_CYCLES / 2;

  // state and strap
  // the strap is read once, in the first cycle after reset release
  // a change of the strap later on has no effect until the next reset
  sbl_state_type  st_q;            // loader state
  logic           boot_q;          // strap captured at reset release
  // receiver
  logic [1:0]     rx_sync_q;       // two-flop input synchroniser
  logic           rx_busy_q;       // inside a character
  logic [15:0]    rx_cnt_q;        // bit timer
  logic [3:0]     rx_bit_q;        // bit index
  logic [7:0]     rx_sh_q;         // shift register
  logic           rx_done_q;       // pulse: byte complete
  logic [7:0]     rx_byte_q;       // completed byte
  // idle and address
  // the idle counter saturates at its limit so it never wraps
  // the store counter is also the ram offset of the next byte
  logic [31:0]    idle_q;          // idle-line cycle counter
  logic [10:0]    cnt_q;           // bytes stored
  // transmitter
  // the echo runs at the receive bit rate but takes one clock more per character,
  // so the buffer gains about one byte per 200 while the host sends back to back
  logic           tx_busy_q;       // inside an echo character
  logic [15:0]    tx_cnt_q;        // bit timer
  logic [3:0]     tx_bit_q;        // bit index
  logic [9:0]     tx_sh_q;         // frame shift register, lsb out first
  // echo fifo wires
  // the buffer decouples storage from the echo timing
  logic [7:0]     ef_data;
  logic           ef_valid;
  logic           ef_in_ready;

  // decode of receiver, limit and transmitter conditions
  // rx_start: line low while no character is in progress
  // rx_tick: the bit timer reached its end
  // byte_in: a completed program byte, sync excluded
  // lim: ram size of the variant in use
  // idle_hit: the line stayed quiet for the whole timeout
  // tx_take: the transmitter is free and a byte waits
  wire rx_in       = rx_sync_q[1];                       // second stage only
  wire rx_start    = !rx_busy_q && !rx_in;
  wire rx_tick     = rx_busy_q && (rx_cnt_q == 16'(BC - 1));
  wire byte_in     = rx_done_q && (st_q == ST_LOAD);
  wire [10:0] lim  = big_ram ? RAM_SIZE_BIG : RAM_SIZE_STD;
  wire ram_full    = (cnt_q == lim);
  wire idle_hit    = (idle_q >= 32'(IDLE_LIMIT));
  wire tx_take     = ef_valid && !tx_busy_q;

  // echo buffer; a full buffer stalls storage of further bytes
  // a byte refused by the buffer is neither stored nor counted,
  // so the host sees it missing from the echo and can resend
  // the buffer pops in the cycle the transmitter takes a byte
  sbl_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_echo (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .in_data   (rx_byte_q),
    .in_valid  (byte_in),
    .in_ready  (ef_in_ready),
    .out_data  (ef_data),
    .out_valid (ef_valid),
    .out_ready (!tx_busy_q)
  );

  // strap capture and loader sequence
  // idle: read the strap, pick the loader or plain start
  // sync: first good character only opens the download
  // load: store and echo until full or quiet
  // done: held until the next reset
  // an illegal code falls back to idle and re-reads the strap
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_q   <= ST_IDLE;
      boot_q <= 1'b0;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          boot_q <= boot_mode;
          st_q   <= boot_mode ? ST_SYNC : ST_DONE;
        end
        ST_SYNC: if (rx_done_q) st_q <= ST_LOAD;          // first char is sync
        ST_LOAD: if (ram_full || idle_hit) st_q <= ST_DONE;
        ST_DONE: st_q <= ST_DONE;
        default: st_q <= ST_IDLE;                          // illegal code recovery
      endcase
    end
  end

  // receiver: sample at mid-bit
  // bit 0 is the start bit, checked again mid-bit to reject glitches
  // bits 1 to 8 are data, lsb first
  // bit 9 is the stop bit; a low stop bit drops the character
  // the line is idle high, so the synchroniser resets to ones
  // to keep a false start away from the first cycles after reset
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rx_sync_q <= 2'h3;
      rx_busy_q <= 1'b0;
      rx_cnt_q  <= '0;
      rx_bit_q  <= '0;
      rx_sh_q   <= '0;
      rx_done_q <= 1'b0;
      rx_byte_q <= '0;
    end else begin
      rx_sync_q <= {rx_sync_q[0], rxd};
      rx_done_q <= 1'b0;
      if (rx_start) begin
        rx_busy_q <= 1'b1;
        rx_cnt_q  <= 16'(BC - HALF);   // first tick lands mid start bit
        rx_bit_q  <= '0;
      end else if (rx_busy_q) begin
        rx_cnt_q <= rx_tick ? 16'h0000 : 16'(rx_cnt_q + 1'b1);
        if (rx_tick) begin
          rx_bit_q <= 4'(rx_bit_q + 1'b1);
          if (rx_bit_q >= 4'h1 && rx_bit_q <= 4'h8) rx_sh_q <= {rx_in, rx_sh_q[7:1]};
          if (rx_bit_q == 4'h0 && rx_in) rx_busy_q <= 1'b0; // false start
          if (rx_bit_q == 4'h9) begin
            rx_busy_q <= 1'b0;
            rx_done_q <= rx_in;        // framing error drops the byte
            rx_byte_q <= rx_sh_q;
          end
        end
      end
    end
  end

  // idle timer and store counter
  // the idle timer runs only while loading and no character is
  // being received; any character start clears it again
  // the timer waits through the sync wait, since a host may be slow
  // to start and the download must not end before the first byte
  // the store counter stops at the ram limit
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      idle_q <= '0;
      cnt_q  <= '0;
    end else begin
      if (rx_busy_q || rx_done_q) idle_q <= '0;
      else if (st_q == ST_LOAD && !idle_hit) idle_q <= 32'(idle_q + 1'b1);
      if (byte_in && ef_in_ready && !ram_full) cnt_q <= 11'(cnt_q + 1'b1);
    end
  end

  // ram write port and visible status
  // the write strobe stands for one cycle per stored byte
  // the address is the base plus the bytes stored so far
  // vectors stay in ram for the whole bootstrap session
  // the jump strobe fires once, in the cycle the loader stops
  // loading covers both the sync wait and the download
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ram_wr       <= '0;
      reset_vector <= LOADER_ROM_LO;
      vec_in_ram   <= 1'b0;
      jump_valid   <= 1'b0;
      jump_addr    <= '0;
      loading      <= 1'b0;
    end else begin
      ram_wr.we    <= byte_in && ef_in_ready && !ram_full;
      ram_wr.addr  <= 16'(RAM_LOAD_BASE + 16'(cnt_q));
      ram_wr.data  <= rx_byte_q;
      reset_vector <= LOADER_ROM_LO;
      vec_in_ram   <= boot_q;
      jump_valid   <= (st_q == ST_LOAD) && (ram_full || idle_hit);
      jump_addr    <= RAM_LOAD_BASE;
      loading      <= (st_q == ST_SYNC) || (st_q == ST_LOAD);
    end
  end

  // transmitter echoing buffered bytes
  // the pin is only ever pulled low; a high level comes from
  // the external pull-up, so the enable carries the data
  // start bit and zero data bits pull low, the rest release
  // the enable trails the shift register by one cycle, which
  // delays the whole echo evenly and keeps bit widths exact
  // the frame is start, eight data bits, stop
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tx_busy_q <= 1'b0;
      tx_cnt_q  <= '0;
      tx_bit_q  <= '0;
      tx_sh_q   <= 10'h3FF;
      txd_o     <= 1'b0;
      txd_oe    <= 1'b0;
    end else begin
      if (tx_take) begin
        tx_busy_q <= 1'b1;
        tx_sh_q   <= {1'b1, ef_data, 1'b0};
        tx_cnt_q  <= '0;
        tx_bit_q  <= '0;
      end else if (tx_busy_q) begin
        if (tx_cnt_q == 16'(BC - 1)) begin
          tx_cnt_q <= '0;
          tx_sh_q  <= {1'b1, tx_sh_q[9:1]};
          tx_bit_q <= 4'(tx_bit_q + 1'b1);
          if (tx_bit_q == 4'(CHAR_BITS - 1)) tx_busy_q <= 1'b0;
        end else begin
          tx_cnt_q <= 16'(tx_cnt_q + 1'b1);
        end
      end
      txd_o  <= 1'b0;                                       // never drives high
      txd_oe <= tx_busy_q && !tx_sh_q[0];                   // pull low only
    end
  end
endmodule
`default_nettype wire

// ---- inc/sbl_pkg.sv ----
// package of constants and types for the serial bootstrap loader
`default_nettype none
package sbl_pkg;
  // address map seen by the loader
  localparam logic [15:0] LOADER_ROM_LO   = 16'hBE00;  // loader rom start
  localparam logic [15:0] LOADER_ROM_HI   = 16'hBFFF;  // loader rom end
  localparam logic [15:0] RAM_LOAD_BASE   = 16'h0080;  // first loaded byte, also entry point
  localparam logic [10:0] RAM_SIZE_STD    = 11'h300;   // 768 bytes
  localparam logic [10:0] RAM_SIZE_BIG    = 11'h400;   // 1 kbyte variant
  // serial timing
  localparam int          CLK_HZ          = 200_000_000;
  localparam int          BAUD_DEFAULT    = 10_000_000; // loader line rate, plain default; short bit time
  localparam int          BIT_CYCLES      = CLK_HZ / BAUD_DEFAULT;
  localparam int          CHAR_BITS       = 10;        // start, 8 data, stop
  localparam int          IDLE_CHARS      = 4;         // idle characters ending download
  localparam int          IDLE_CYCLES     = BIT_CYCLES * CHAR_BITS * IDLE_CHARS;
  localparam logic [7:0]  SYNC_CHAR       = 8'hFF;     // synchronization character
  localparam int          FIFO_DEPTH      = 16;        // echo buffer depth
  localparam int          FIFO_WIDTH      = 8;
  // one ram write
  typedef struct packed {
    logic        we;
    logic [15:0] addr;
    logic [7:0]  data;
  } sbl_ram_wr_type;
  // loader states
  typedef enum logic [2:0] {ST_IDLE, ST_SYNC, ST_LOAD, ST_DONE} sbl_state_type;
endpackage
`default_nettype wire

// ---- design/sbl_fifo.sv ----
// parameterised flip-flop fifo with valid/ready on both sides
`default_nettype none
module sbl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output var  logic             in_ready,
  output var  logic [WIDTH-1:0] out_data,
  output var  logic             out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];   // storage entries
  logic [AW-1:0]    wr_q;            // write index
  logic [AW-1:0]    rd_q;            // read index
  logic [AW:0]      cnt_q;           // fill level
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;
  // room left while the level is below the depth
  assign in_ready  = (cnt_q < (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  // pointer and level bookkeeping
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= AW'(wr_q + 1'b1);
      if (pop) rd_q <= AW'(rd_q + 1'b1);
      cnt_q <= (AW+1)'(cnt_q + (AW+1)'(push) - (AW+1)'(pop));
    end
  end
  // data entries have no reset
  always_ff @(posedge clk_sys) begin
    if (push) mem_q[wr_q] <= in_data;
  end
endmodule
`default_nettype wire

// ---- tb/sbl_loader_props.sv ----
// port checker for the serial bootstrap loader
`default_nettype none
module sbl_loader_props
  import sbl_pkg::*;
#(
  parameter int IDLE_LIMIT = 2000
) (
  input wire logic           clk_sys,
  input wire logic           reset,
  input wire logic           boot_mode,
  input wire logic           big_ram,
  input wire logic           rxd,
  input wire logic           txd_o,
  input wire logic           txd_oe,
  input wire sbl_ram_wr_type ram_wr,
  input wire logic [15:0]    reset_vector,
  input wire logic           vec_in_ram,
  input wire logic           jump_valid,
  input wire logic [15:0]    jump_addr,
  input wire logic           loading
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SLACK = CHAR_BITS * BIT_CYCLES + 8; // stop sample trails the last rise
  int idle_cnt; // raw receive line high time
  int wr_cnt;   // bytes stored so far
  int tx_quiet; // transmit pin released time
  // the idle counter runs ahead of the design's own and wr_cnt one cycle behind the store counter, so bounds stay safe
  always_ff @(posedge clk_sys) begin
    idle_cnt <= (reset || !rxd) ? 0 : idle_cnt + 1;
    wr_cnt   <= reset ? 0 : wr_cnt + int'(ram_wr.we);
    tx_quiet <= (reset || txd_oe) ? 0 : tx_quiet + 1;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  a_vector_in_rom:
    assert property (reset_vector >= LOADER_ROM_LO && reset_vector <= LOADER_ROM_HI) else $error("vector off rom");
  a_store_addr_next:
    assert property (ram_wr.we |-> ram_wr.addr == RAM_LOAD_BASE + 16'(wr_cnt)) else $error("store address");
  a_store_within_ram:
    assert property (ram_wr.we |-> wr_cnt < (big_ram ? 1024 : 768)) else $error("store past ram");
  a_echo_starts:
    assert property (ram_wr.we && tx_quiet >= SLACK |-> ##[1:3] txd_oe) else $error("no echo start");
  a_idle_ends_load:
    assert property (loading && wr_cnt > 0 |-> idle_cnt <= IDLE_LIMIT + SLACK) else $error("idle too long");
  a_no_early_jump:
    assert property (jump_valid |-> idle_cnt >= IDLE_LIMIT || wr_cnt == 768 || wr_cnt == 1024) else $error("early jump");
  a_jump_target:
    assert property (jump_valid |-> jump_addr == RAM_LOAD_BASE ##1 (!jump_valid && !loading)) else $error("bad jump");
  a_vectors_in_ram:
    assert property (loading |-> vec_in_ram) else $error("vectors not in ram");
  a_drain_only:
    assert property (txd_o == 1'b0) else $error("pin driven high");
  c_store: cover property (ram_wr.we);
  c_echo: cover property ($rose(txd_oe));
  c_jump: cover property (jump_valid);
endmodule
bind sbl_loader sbl_loader_props #(.IDLE_LIMIT(IDLE_LIMIT)) u_sbl_loader_props (.clk_sys, .reset,
  .boot_mode, .big_ram, .rxd, .txd_o, .txd_oe, .ram_wr, .reset_vector, .vec_in_ram, .jump_valid, .jump_addr, .loading);
`default_nettype wire

// ---- tb/sbl_host.sv ----
// behavioural host: sends characters, collects the echo
`default_nettype none
module sbl_host
  import sbl_pkg::*;
(
  input  wire logic clk_sys,
  output var  logic rxd,
  input  wire logic txd_wire
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] echo_q[$]; // bytes heard back
  initial rxd = 1'b1;    // idle line high
  // one 8n1 character, lsb first, on falling edges
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < CHAR_BITS; i++) begin
      rxd = f[i];
      repeat (BIT_CYCLES) @(negedge clk_sys);
    end
  endtask
  task automatic send_sync;
    send_byte(SYNC_CHAR);
  endtask
  // mid-bit sampling of the echo
  initial forever begin
    logic [7:0] b;
    @(negedge txd_wire);
    repeat (BIT_CYCLES / 2) @(posedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYCLES) @(posedge clk_sys);
      b[i] = txd_wire;
    end
    repeat (BIT_CYCLES) @(posedge clk_sys);
    echo_q.push_back(b);
  end
endmodule
`default_nettype wire

// ---- tb/sbl_loader_bench.sv ----
// bench for the serial bootstrap loader
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin mismatches++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, e); end end
module sbl_loader_bench;
  import sbl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int IDLE_SIM = 4 * BIT_CYCLES; // shortened timeout, longer than half a stop bit
  logic           clk_sys, reset, boot_mode, big_ram, rxd, txd_o, txd_oe, vec_in_ram, jump_valid, loading;
  sbl_ram_wr_type ram_wr;
  logic [15:0]    reset_vector, jump_addr, jaddr;
  logic [15:0]    wa_q[$]; // stored addresses
  logic [7:0]     wd_q[$]; // stored data
  int             mismatches = 0;
  int             cmp_count = 0;
  int             jumps = 0;
  wire            txd_wire = txd_oe ? txd_o : 1'b1; // pull-up when released
  sbl_loader #(.IDLE_LIMIT(IDLE_SIM)) u_sbl_loader (.clk_sys, .reset, .boot_mode, .big_ram, .rxd, .txd_o,
    .txd_oe, .ram_wr, .reset_vector, .vec_in_ram, .jump_valid, .jump_addr, .loading);
  sbl_host u_sbl_host (.clk_sys, .rxd, .txd_wire);
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // record stores and jumps as they happen
  always @(posedge clk_sys) begin
    if (ram_wr.we === 1'b1) begin
      wa_q.push_back(ram_wr.addr);
      wd_q.push_back(ram_wr.data);
    end
    if (jump_valid === 1'b1) begin
      jumps++;
      jaddr = jump_addr;
    end
  end
  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic do_reset(input logic boot);
    reset = 1'b1;
    boot_mode = boot;
    repeat (3) @(negedge clk_sys);
    reset = 1'b0;
    wa_q.delete();
    wd_q.delete();
    jumps = 0;
    repeat (4) @(negedge clk_sys);
  endtask
  // normal reset: no loader activity
  task automatic t_no_boot;
    do_reset(1'b0);
    repeat (50) @(negedge clk_sys);
    `CHK(reset_vector, LOADER_ROM_LO)
    `CHK(vec_in_ram, 1'b0)
    `CHK(jumps, 0)
    $display("test no_boot done");
  endtask
  // sync, two bytes with long gaps, then idle end
  task automatic t_download;
    int n;
    do_reset(1'b1);
    `CHK(vec_in_ram, 1'b1)
    u_sbl_host.send_sync();
    repeat (IDLE_SIM - BIT_CYCLES) @(negedge clk_sys);
    u_sbl_host.send_byte(8'hA5);
    repeat (IDLE_SIM - BIT_CYCLES) @(negedge clk_sys);
    `CHK(loading, 1'b1)
    u_sbl_host.send_byte(8'h3C);
    n = 0;
    while ((jumps == 0 || u_sbl_host.echo_q.size() < 2) && n < 16 * BIT_CYCLES) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 16 * BIT_CYCLES) begin
      mismatches++;
      end_of_test();
    end else begin
    `CHK(jumps, 1)
    `CHK(loading, 1'b0)
    `CHK(jaddr, RAM_LOAD_BASE)
    `CHK(wa_q.size(), 2)
    `CHK(wa_q[0], RAM_LOAD_BASE)
    `CHK(wa_q[1], RAM_LOAD_BASE + 16'h0001)
    `CHK(wd_q[0], 8'hA5)
    `CHK(wd_q[1], 8'h3C)
    `CHK(u_sbl_host.echo_q[0], 8'hA5)
    `CHK(u_sbl_host.echo_q[1], 8'h3C)
    end
    $display("test download done");
  endtask
  initial begin
    reset = 1'b1;
    boot_mode = 1'b1;
    big_ram = 1'b0;
    t_no_boot();
    t_download();
    end_of_test();
  end
endmodule
`default_nettype wire
